// ---- verilog/lsfs_map.vh ----
// Operation
// - sample serial input into receive shifter on each rising serial clock, select low
// - select high: ignore clock and data, serial output undriven
// - one sixteen-bit word per transfer, most significant bit first
// - select low starts a transfer; commit only at select rising after sixteen bits
// - more or fewer than sixteen rising edges: drop write, set serial error
// - rejected transfer leaves diagnostic contents untouched
// - outgoing serial error flag shows the previous transfer's outcome
// - response shifts out msb first, next bit on each falling clock
// - summary fault flag appears as soon as select falls
// - frame: address 15:11, write select, don't-care, eight data, parity bit 0
// - write select 0 reads: data bits ignored, register contents returned
// - read response: seven status bits, register data 8:1, parity
// - write select 1: data written to addressed register at select rising
// - write response: status, then overcurrent, fset, zero, switch, thermal, zeros
// - frame parity odd over all sixteen bits
// - bad parity sets serial error; a write is also dropped
// - memory error reported in every response
//
`ifndef LSFS_MAP_VH
`define LSFS_MAP_VH

`define LSFS_CNT_W     5
`define LSFS_CNT_FULL  5'h10
`define LSFS_CNT_OVER  5'h11
`define LSFS_CNT_ADDR  5'h04
`define LSFS_CNT_FILL  5'h05
`define LSFS_IDX_TOP   4'hf
`define LSFS_ADDR_HI   15
`define LSFS_ADDR_LO   11
`define LSFS_WR_BIT    10
`define LSFS_DATA_HI   8
`define LSFS_DATA_LO   1
`define LSFS_PAR_BIT   0
`define LSFS_PIN_RST   3'b110

`endif

// ---- verilog/lsfs_spi_slave.v ----
`timescale 1ns/1ps
`default_nettype none
`include "lsfs_map.vh"

module lsfs_spi_slave (
    input  wire       clk_sys,
    input  wire       rst_b,
    input  wire       chip_select_n,
    input  wire       sck,
    input  wire       mosi,
    output wire       miso,
    output wire       miso_oe,
    input  wire       summary_fault_flag,
    input  wire       memory_error_flag,
    input  wire       output_overvoltage_bit,
    input  wire       output_undervoltage_bit,
    input  wire       open_string_bit,
    input  wire       regulator_undervoltage_bit,
    input  wire       output_overcurrent_bit,
    input  wire       frequency_set_fault_bit,
    input  wire       switch_current_fault_bit,
    input  wire       thermal_fault_bit,
    output wire [4:0] reg_rd_addr,
    input  wire [7:0] reg_rd_data,
    output wire [4:0] reg_wr_addr,
    output wire [7:0] reg_wr_data,
    output wire       reg_wr_strobe,
    output wire       serial_error_flag
);

// ----------------------------------------------------------------
// pin synchronisers
// ----------------------------------------------------------------
// bit 2 select, bit 1 clock, bit 0 data; all three share the
// same latency so data stays aligned with the clock edges
wire [2:0] pin_in;
wire [2:0] pin_rst;
wire [2:0] filt_q;
wire [2:0] filt_prev_q;

assign pin_in  = {chip_select_n, sck, mosi};
// reset to the idle levels of the pins, so that no false
// select or clock edge appears right after reset
assign pin_rst = `LSFS_PIN_RST;

genvar g;
generate
    for (g = 0; g < 3; g = g + 1) begin : g_sync
        // each bit keeps its own stages, so every flop has one driver
        reg sync1_q;
        reg sync2_q;
        reg sync3_q;
        reg filt_bit_q;
        reg filt_prev_bit_q;

        always @(posedge clk_sys) begin
            if (!rst_b) begin
                sync1_q         <= pin_rst[g];
                sync2_q         <= pin_rst[g];
                sync3_q         <= pin_rst[g];
                filt_bit_q      <= pin_rst[g];
                filt_prev_bit_q <= pin_rst[g];
            end else begin
                sync1_q         <= pin_in[g];
                sync2_q         <= sync1_q;
                sync3_q         <= sync2_q;
                // a change counts only once two stages agree
                if (sync2_q == sync3_q) begin
                    filt_bit_q <= sync3_q;
                end
                filt_prev_bit_q <= filt_bit_q;
            end
        end

        assign filt_q[g]      = filt_bit_q;
        assign filt_prev_q[g] = filt_prev_bit_q;
    end
endgenerate

// ----------------------------------------------------------------
// edge detection
// ----------------------------------------------------------------
wire cs_low;
wire cs_fall;
wire cs_rise;
wire sck_rise;
wire sck_fall;
wire data_bit;

assign cs_low   = ~filt_q[2];
assign cs_fall  = filt_prev_q[2] & ~filt_q[2];
assign cs_rise  = ~filt_prev_q[2] & filt_q[2];
// clock activity only counts while selected
assign sck_rise = cs_low & ~cs_fall & ~filt_prev_q[1] & filt_q[1];
// falls move the pin, rises feed the shifter
assign sck_fall = cs_low & ~cs_fall & filt_prev_q[1] & ~filt_q[1];
assign data_bit = filt_q[0];

// ----------------------------------------------------------------
// receive side
// ----------------------------------------------------------------
reg [15:0]            rx_q;
reg [15:0]            rx_d;
reg [`LSFS_CNT_W-1:0] cnt_q;
reg [`LSFS_CNT_W-1:0] cnt_d;
reg [4:0]             rd_addr_q;
reg [4:0]             rd_addr_d;

always @* begin
    rx_d      = rx_q;
    cnt_d     = cnt_q;
    rd_addr_d = rd_addr_q;
    if (cs_fall) begin
        // a fresh frame starts empty, so a cut frame leaves nothing behind
        rx_d  = 16'h0000;
        cnt_d = {`LSFS_CNT_W{1'b0}};
    end else if (sck_rise) begin
        rx_d = {rx_q[14:0], data_bit};
        // saturate past sixteen so an overrun stays visible
        if (cnt_q != `LSFS_CNT_OVER) begin
            cnt_d = cnt_q + 5'h01;
        end
        // fifth bit completes the address; it is handed out early
        // so the register file has a full clock period to answer
        if (cnt_q == `LSFS_CNT_ADDR) begin
            rd_addr_d = {rx_q[3:0], data_bit};
        end
    end
end

always @(posedge clk_sys) begin
    if (!rst_b) begin
        rx_q      <= 16'h0000;
        cnt_q     <= {`LSFS_CNT_W{1'b0}};
        rd_addr_q <= 5'h00;
    end else begin
        rx_q      <= rx_d;
        cnt_q     <= cnt_d;
        rd_addr_q <= rd_addr_d;
    end
end

// ----------------------------------------------------------------
// response frame
// ----------------------------------------------------------------
reg  [15:0] resp_q;
reg  [15:0] resp_d;
reg  [3:0]  idx_q;
reg  [3:0]  idx_d;
reg         miso_q;
reg         miso_d;
reg         oe_q;
reg         se_q;
wire [7:0]  low_bits;
wire        wr_sel;
wire        resp_par;

// low bits are chosen once per frame, on the sixth rising edge,
// whose own data bit is the write select
assign wr_sel = data_bit;

// a read returns the register, a write the extra fault bits
assign low_bits = wr_sel ?
    {output_overcurrent_bit, frequency_set_fault_bit, 1'b0,
     switch_current_fault_bit, thermal_fault_bit, 3'b000} :
    reg_rd_data;

// odd parity over the whole outgoing word
assign resp_par = ~(^{resp_q[15:9], low_bits});

always @* begin
    resp_d = resp_q;
    idx_d  = idx_q;
    if (cs_fall) begin
        // status is frozen for the whole transfer
        resp_d = {summary_fault_flag,
                  memory_error_flag,
                  se_q,
                  output_overvoltage_bit,
                  output_undervoltage_bit,
                  open_string_bit,
                  regulator_undervoltage_bit,
                  9'h000};
        idx_d  = `LSFS_IDX_TOP;
    end else begin
        // the clock idles high, so the seventh falling edge, which
        // puts bit 8 out, comes before the seventh rising edge;
        // filling on the sixth keeps the pin still between falls
        if (sck_rise && cnt_q == `LSFS_CNT_FILL) begin
            resp_d[`LSFS_DATA_HI:`LSFS_DATA_LO] = low_bits;
            resp_d[`LSFS_PAR_BIT] = resp_par;
        end
        // the index rests on bit 0 after an overrun
        if (sck_fall && idx_q != 4'h0) begin
            idx_d = idx_q - 4'h1;
        end
    end
end

always @(posedge clk_sys) begin
    if (!rst_b) begin
        resp_q <= 16'h0000;
        idx_q  <= `LSFS_IDX_TOP;
    end else begin
        resp_q <= resp_d;
        idx_q  <= idx_d;
    end
end

// ----------------------------------------------------------------
// serial output pin
// ----------------------------------------------------------------
always @* begin
    miso_d = 1'b0;
    if (cs_fall) begin
        // fault flag goes out before any clock edge; it is taken
        // live because the frozen copy lands in this same cycle
        miso_d = summary_fault_flag;
    end else if (cs_low) begin
        miso_d = resp_q[idx_q];
    end
end

always @(posedge clk_sys) begin
    if (!rst_b) begin
        miso_q <= 1'b0;
        oe_q   <= 1'b0;
    end else begin
        // the pin idles low while released, never at a stale bit
        miso_q <= miso_d;
        oe_q   <= cs_low;
    end
end

// ----------------------------------------------------------------
// commit at end of frame
// ----------------------------------------------------------------
wire bad_count;
wire bad_parity;
wire frame_err;

// a frame counts only with exactly sixteen rising edges and
// an odd number of ones; either fault blocks the write
assign bad_count  = cnt_q != `LSFS_CNT_FULL;
assign bad_parity = ~(^rx_q);
assign frame_err  = bad_count | bad_parity;

reg [4:0] wr_addr_q;
reg [4:0] wr_addr_d;
reg [7:0] wr_data_q;
reg [7:0] wr_data_d;
reg       wr_stb_q;
reg       wr_stb_d;
reg       se_d;

always @* begin
    se_d      = se_q;
    wr_addr_d = wr_addr_q;
    wr_data_d = wr_data_q;
    wr_stb_d  = 1'b0;
    if (cs_rise) begin
        // flag always describes the last finished frame
        se_d = frame_err;
        // rejected frames emit nothing, so the diagnostic
        // registers keep their contents
        if (!frame_err && rx_q[`LSFS_WR_BIT]) begin
            wr_addr_d = rx_q[`LSFS_ADDR_HI:`LSFS_ADDR_LO];
            wr_data_d = rx_q[`LSFS_DATA_HI:`LSFS_DATA_LO];
            wr_stb_d  = 1'b1;
        end
    end
end

always @(posedge clk_sys) begin
    if (!rst_b) begin
        se_q      <= 1'b0;
        wr_addr_q <= 5'h00;
        wr_data_q <= 8'h00;
        wr_stb_q  <= 1'b0;
    end else begin
        se_q      <= se_d;
        wr_addr_q <= wr_addr_d;
        wr_data_q <= wr_data_d;
        wr_stb_q  <= wr_stb_d;
    end
end

// ----------------------------------------------------------------
// outputs
// ----------------------------------------------------------------
// every output leaves straight from a flop
assign miso              = miso_q;
assign miso_oe           = oe_q;
assign reg_rd_addr       = rd_addr_q;
assign reg_wr_addr       = wr_addr_q;
assign reg_wr_data       = wr_data_q;
assign reg_wr_strobe     = wr_stb_q;
assign serial_error_flag = se_q;

endmodule

`default_nettype wire

// ---- tb/lsfs_props.sv ----
`timescale 1ns/1ps
`default_nettype none
module lsfs_props (
    input wire logic clk_sys,
    input wire logic rst_b,
    input wire logic chip_select_n,
    input wire logic sck,
    input wire logic miso,
    input wire logic miso_oe,
    input wire logic summary_fault_flag,
    input wire logic reg_wr_strobe,
    input wire logic serial_error_flag
);
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!rst_b);
    a_idle_no_drive: assert property (chip_select_n [*8] |-> !miso_oe)
        else $error("miso driven while idle");
    a_frame_drives: assert property (!chip_select_n [*8] |-> miso_oe)
        else $error("miso not driven in frame");
    a_idle_low: assert property (!miso_oe |-> !miso)
        else $error("miso not low while undriven");
    a_first_fault: assert property ($rose(miso_oe) |-> miso == summary_fault_flag)
        else $error("first bit is not the fault flag");
    a_strobe_pulse: assert property (reg_wr_strobe |=> !reg_wr_strobe)
        else $error("write strobe longer than one cycle");
    a_commit_late: assert property (reg_wr_strobe |-> chip_select_n && $past(chip_select_n, 3))
        else $error("write committed before select rose");
    a_error_holds: assert property (!chip_select_n [*6] |-> $stable(serial_error_flag))
        else $error("serial error changed inside a frame");
    a_shift_fall: assert property (!chip_select_n && miso_oe && $past(miso_oe) && $changed(miso)
        |-> !$past(sck, 3))
        else $error("miso changed without a falling clock");
    cover property (reg_wr_strobe);
    cover property ($rose(serial_error_flag));
    cover property ($fell(serial_error_flag));
endmodule
bind lsfs_spi_slave lsfs_props u_props (.*);
`default_nettype wire

// ---- tb/lsfs_master_model.sv ----
`timescale 1ns/1ps
`default_nettype none
module lsfs_master_model (
    input  wire logic clk_sys,
    input  wire logic miso,
    output logic      chip_select_n,
    output logic      sck,
    output logic      mosi
);
    initial begin
        chip_select_n = 1'h1;
        sck = 1'h1;
        mosi = 1'h0;
    end
    task automatic step(input int n);
        repeat (n) @(posedge clk_sys);
        #1;
    endtask
    // miso is read just before the next fall, since the device answers late
    task automatic frame(input logic [15:0] tx, input int n, output logic [15:0] rx);
        rx = 16'h0;
        step(1);
        chip_select_n = 1'h0;
        for (int i = 0; i < n; i++) begin
            step(8);
            rx = {rx[14:0], miso};
            sck = 1'h0;
            mosi = (i < 16) ? tx[15 - i] : 1'h0;
            step(4);
            sck = 1'h1;
        end
        step(8);
        chip_select_n = 1'h1;
        mosi = 1'h0;
        step(8);
    endtask
endmodule
`default_nettype wire

// ---- tb/tb_top.sv ----
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    logic       clk_sys = 1'h0;
    logic       rst_b = 1'h0;
    logic [9:0] flt = 10'h0;
    logic [7:0] regs [32];
    logic [7:0] shadow [32];
    logic       se_exp = 1'h0;
    int         fails = 0;
    int         checks = 0;
    wire        chip_select_n, sck, mosi, miso, ws, se;
    wire  [4:0] ra, wa;
    wire  [7:0] wd;
    wire  [7:0] rd = regs[ra];
    always #12.5 clk_sys = ~clk_sys;
    always @(posedge clk_sys) if (ws) regs[wa] <= wd;
    lsfs_spi_slave dut (
        .clk_sys(clk_sys), .rst_b(rst_b), .chip_select_n(chip_select_n), .sck(sck), .mosi(mosi),
        .miso(miso), .miso_oe(), .summary_fault_flag(flt[9]), .memory_error_flag(flt[8]),
        .output_overvoltage_bit(flt[7]), .output_undervoltage_bit(flt[6]), .open_string_bit(flt[5]),
        .regulator_undervoltage_bit(flt[4]), .output_overcurrent_bit(flt[3]),
        .frequency_set_fault_bit(flt[2]), .switch_current_fault_bit(flt[1]), .thermal_fault_bit(flt[0]),
        .reg_rd_addr(ra), .reg_rd_data(rd), .reg_wr_addr(wa), .reg_wr_data(wd), .reg_wr_strobe(ws),
        .serial_error_flag(se));
    lsfs_master_model u_master (.clk_sys(clk_sys), .miso(miso), .chip_select_n(chip_select_n),
        .sck(sck), .mosi(mosi));
    function automatic logic [15:0] mk(input logic [4:0] a, input logic w, input logic [7:0] d);
        mk = {a, w, 1'h1, d, 1'h0};
        mk[0] = ~^mk;
    endfunction
    task automatic chk(input string n, input logic [15:0] e, input logic [15:0] s);
        checks++;
        if (e !== s) begin
            fails++;
            $display("BAD %s expected %h seen %h", n, e, s);
        end
    endtask
    task automatic xfer(input logic [15:0] f, input int n, input logic [9:0] v);
        logic [15:0] rx;
        logic [15:0] e;
        logic        bad;
        flt = v;
        bad = (n != 16) || !(^f);
        e[15:9] = {v[9:8], se_exp, v[7:4]};
        e[8:1] = f[10] ? {v[3:2], 1'h0, v[1:0], 3'h0} : shadow[f[15:11]];
        e[0] = ~^e[15:1];
        u_master.frame(f, n, rx);
        if (n == 16) chk("response", e, rx);
        if (!bad && f[10]) shadow[f[15:11]] = f[8:1];
        repeat (4) @(posedge clk_sys);
        chk("serial_error_flag", {15'h0, bad}, {15'h0, se});
        chk("register", {8'h0, shadow[f[15:11]]}, {8'h0, regs[f[15:11]]});
        se_exp = bad;
        #1;
    endtask
    task automatic give_verdict;
        if (fails == 0 && checks > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask
    initial begin
        for (int i = 0; i < 32; i++) begin
            regs[i] = 8'h0;
            shadow[i] = 8'h0;
        end
        repeat (5) @(posedge clk_sys);
        #1;
        rst_b = 1'h1;
        repeat (6) @(posedge clk_sys);
        #1;
        xfer(mk(5'h05, 1'h1, 8'ha5), 16, 10'h2aa);
        xfer(mk(5'h05, 1'h0, 8'h3c), 16, 10'h155);
        xfer(mk(5'h06, 1'h1, 8'hff), 15, 10'h3ff);
        xfer(mk(5'h06, 1'h0, 8'h00), 16, 10'h000);
        xfer(mk(5'h06, 1'h1, 8'h5a), 17, 10'h200);
        xfer(mk(5'h07, 1'h1, 8'h81) ^ 16'h1, 16, 10'h100);
        xfer(mk(5'h05, 1'h0, 8'h00) ^ 16'h1, 16, 10'h0ff);
        xfer(mk(5'h1f, 1'h1, 8'h01), 16, 10'h001);
        xfer(mk(5'h1f, 1'h0, 8'h00), 16, 10'h3fe);
        give_verdict;
    end
    initial begin
        #200000;
        fails++;
        give_verdict;
    end
endmodule
`default_nettype wire
